// ===== src/epp_cycle_engine.sv
// EPP cycle engine: host port requests to strobe and hold handshakes
//
// Operation
// - EPP data ports at offsets 06H and 07H act like data port 0, EPP only.
// - Outside EPP cycles, pins follow control register and direction bit.
// - 1.9: abort and set status bit 0 after 10us without hold release.
// - 1.7: abort and set status bit 0 when a cycle exceeds 10us.
// - Active strobe bit during a cycle forces driving bus and write asserted.
// - Write with direction bit set runs as a read, no error.
// - 1.9 write stretched; hold low at strobe, complete on its return high.
// - 1.9 write with hold high waits for it low before changing outputs.
// - 1.9 write drives byte, output direction, write low, then strobe.
// - 1.9 write ends strobe after hold release; peripheral latched byte.
// - 1.9 write end keeps byte latched and returns ready to host.
// - 1.9 read floats bus, releases write, then asserts a strobe.
// - 1.9 read with hold high waits for it low first, ends on high.
// - 1.9 read captures bus byte at hold release, then drops strobe.
// - 1.9 read ends with ready and the captured byte to host.
// - 1.7 stretches host cycle while hold low, completes on high or timeout.
// - 1.7 write: software clears direction, device drives byte and strobe.
// - 1.7 write end: ready, strobe released, byte stays latched.
// - Timeout bit cleared by reset or writing 1; writing 0 ignored.
// - Direction bit 5: 0 output, 1 input in bidirectional or EPP mode.
`timescale 1ns/1ps
`default_nettype none
`include "epp_engine_regs.svh"

module epp_cycle_engine (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // Mode selection
  input wire logic epp_mode_in,
  input wire logic epp_v17_in,
  input wire logic bidir_mode_in,
  // Host I/O requests
  input wire logic io_valid_in,
  output logic io_ready_out,
  input wire logic io_write_in,
  input wire logic [2:0] io_addr_in,
  input wire logic [7:0] io_wdata_in,
  output logic io_done_out,
  output logic [7:0] io_rdata_out,
  output logic lpc_wait_sync_out,
  // Parallel data bus
  input wire logic [7:0] parallel_data_lines_in,
  output logic [7:0] parallel_data_lines_out,
  output logic parallel_data_oe_n_out,
  // Parallel control outputs
  output logic write_n_out,
  output logic data_strobe_n_out,
  output logic address_strobe_n_out,
  output logic init_n_out,
  // Parallel status inputs
  input wire logic periph_hold_n_in,
  input wire logic ack_n_in,
  input wire logic paper_end_in,
  input wire logic select_in,
  input wire logic error_n_in,
  // Status
  output logic timeout_flag_out
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  localparam logic [`TMO_CNT_W-1:0] TMO_LAST =
    `TMO_CNT_W'(`TMO_CYC - 1);

  epp_engine_pkg::eng_state_e state_ff;
  epp_engine_pkg::eng_state_e nxt_state;
  logic [5:0] ctrl_ff;
  logic [5:0] nxt_ctrl;
  logic [7:0] out_ff;
  logic [7:0] nxt_out;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic [7:0] cmd_data_ff;
  logic [7:0] nxt_cmd_data;
  logic cyc_wr_ff;
  logic nxt_cyc_wr;
  logic cyc_addr_ff;
  logic nxt_cyc_addr;
  logic tmo_ff;
  logic nxt_tmo;
  logic done_ff;
  logic nxt_done;
  logic [`TMO_CNT_W-1:0] cnt_ff;
  logic [`TMO_CNT_W-1:0] nxt_cnt;
  logic fifo_valid;
  logic fifo_pop;
  logic [11:0] fifo_data;
  logic req_wr;
  logic [2:0] req_addr;
  logic [7:0] req_wdata;
  logic [12:0] pins_sync;
  logic hold_n;
  logic [7:0] bus_in;
  logic [7:0] status_rd;
  logic in_cycle;
  logic strobe_on;
  logic pins_in_mode;

  // ----------------------------------------------------------------------
  // Request buffer and pin synchronisers
  // ----------------------------------------------------------------------
  req_fifo #(
    .WIDTH(`FIFO_WIDTH),
    .DEPTH(`FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .in_valid_in(io_valid_in),
    .in_ready_out(io_ready_out),
    .in_data_in({io_write_in, io_addr_in, io_wdata_in}),
    .out_valid_out(fifo_valid),
    .out_ready_in(fifo_pop),
    .out_data_out(fifo_data)
  );

  pin_sync #(
    .WIDTH(13)
  ) u_sync (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .pin_in({periph_hold_n_in, parallel_data_lines_in, ack_n_in,
             paper_end_in, select_in, error_n_in}),
    .init_in({periph_hold_n_in, parallel_data_lines_in, ack_n_in,
              paper_end_in, select_in, error_n_in}),
    .level_out(pins_sync)
  );

  // Field split of the request word and synchronised pins
  assign req_wr = fifo_data[11];
  assign req_addr = fifo_data[10:8];
  assign req_wdata = fifo_data[7:0];
  assign hold_n = pins_sync[12];
  assign bus_in = pins_sync[11:4];
  assign fifo_pop = (state_ff == epp_engine_pkg::ST_IDLE) && fifo_valid;
  assign status_rd = {~hold_n, pins_sync[3:0], 2'b00, tmo_ff};

  // ----------------------------------------------------------------------
  // Cycle engine next state
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_ctrl = ctrl_ff;
    nxt_out = out_ff;
    nxt_rdata = rdata_ff;
    nxt_cmd_data = cmd_data_ff;
    nxt_cyc_wr = cyc_wr_ff;
    nxt_cyc_addr = cyc_addr_ff;
    nxt_tmo = tmo_ff;
    nxt_done = 1'b0;
    nxt_cnt = cnt_ff;
    case (state_ff)
      epp_engine_pkg::ST_IDLE: begin
        if (fifo_valid) begin
          nxt_done = 1'b1;
          nxt_rdata = 8'h00;
          case (req_addr)
            `OFF_DATA: begin
              if (req_wr) begin
                nxt_out = req_wdata;
              end else begin
                nxt_rdata = pins_in_mode ? bus_in : out_ff;
              end
            end
            `OFF_STATUS: begin
              if (req_wr && req_wdata[`STAT_TIMEOUT]) begin
                nxt_tmo = 1'b0;
              end else if (!req_wr) begin
                nxt_rdata = status_rd;
              end
            end
            `OFF_CONTROL: begin
              if (req_wr) begin
                nxt_ctrl = req_wdata[5:0];
              end else begin
                nxt_rdata = {2'b00, ctrl_ff};
              end
            end
            default: begin
              // Offsets 03H to 07H start a cycle only in EPP mode
              if (!epp_mode_in) begin
                nxt_rdata = req_wr ? 8'h00 : `READ_IDLE;
              end else begin
                nxt_done = 1'b0;
                nxt_cyc_addr = (req_addr == `OFF_EPP_ADDR);
                nxt_cyc_wr = req_wr && !ctrl_ff[`CTRL_DIR];
                nxt_cmd_data = req_wdata;
                nxt_cnt = '0;
                if (!epp_v17_in && hold_n) begin
                  nxt_state = epp_engine_pkg::ST_WAIT_LOW;
                end else begin
                  nxt_state = epp_engine_pkg::ST_SETUP;
                  // Byte goes out a cycle ahead of the strobe
                  if (nxt_cyc_wr) begin
                    nxt_out = req_wdata;
                  end
                end
              end
            end
          endcase
        end
      end
      epp_engine_pkg::ST_WAIT_LOW: begin
        nxt_cnt = cnt_ff + 1'b1;
        if (!hold_n) begin
          nxt_state = epp_engine_pkg::ST_SETUP;
          if (cyc_wr_ff) begin
            nxt_out = cmd_data_ff;
          end
        end
      end
      epp_engine_pkg::ST_SETUP: begin
        // Byte and direction settle one cycle before the strobe
        nxt_cnt = cnt_ff + 1'b1;
        nxt_state = epp_engine_pkg::ST_STROBE;
      end
      epp_engine_pkg::ST_STROBE: begin
        nxt_cnt = cnt_ff + 1'b1;
        if (hold_n) begin
          nxt_rdata = cyc_wr_ff ? 8'h00 : bus_in;
          nxt_state = epp_engine_pkg::ST_FINISH;
        end
      end
      epp_engine_pkg::ST_FINISH: begin
        nxt_done = 1'b1;
        nxt_state = epp_engine_pkg::ST_IDLE;
      end
      default: begin
        nxt_state = epp_engine_pkg::ST_IDLE;
      end
    endcase
    // Watchdog: cycle start to hold release, abort and flag
    if (((state_ff == epp_engine_pkg::ST_WAIT_LOW) ||
         (state_ff == epp_engine_pkg::ST_SETUP) ||
         (state_ff == epp_engine_pkg::ST_STROBE)) &&
        (cnt_ff == TMO_LAST) && !(state_ff == epp_engine_pkg::ST_STROBE &&
        hold_n)) begin
      nxt_tmo = 1'b1;
      nxt_rdata = `READ_IDLE;
      nxt_state = epp_engine_pkg::ST_FINISH;
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_ff <= epp_engine_pkg::ST_IDLE;
      ctrl_ff <= `CTRL_RESET;
      out_ff <= `DATA_RESET;
      rdata_ff <= 8'h00;
      cmd_data_ff <= 8'h00;
      cyc_wr_ff <= 1'b0;
      cyc_addr_ff <= 1'b0;
      tmo_ff <= 1'b0;
      done_ff <= 1'b0;
      cnt_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      ctrl_ff <= nxt_ctrl;
      out_ff <= nxt_out;
      rdata_ff <= nxt_rdata;
      cmd_data_ff <= nxt_cmd_data;
      cyc_wr_ff <= nxt_cyc_wr;
      cyc_addr_ff <= nxt_cyc_addr;
      tmo_ff <= nxt_tmo;
      done_ff <= nxt_done;
      cnt_ff <= nxt_cnt;
    end
  end

  // ----------------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------------
  // Cycle owns the pins only once outputs may change
  assign in_cycle = (state_ff == epp_engine_pkg::ST_SETUP) ||
                    (state_ff == epp_engine_pkg::ST_STROBE);
  assign strobe_on = (state_ff == epp_engine_pkg::ST_STROBE);
  // Input direction only outside printer-only mode
  assign pins_in_mode = ctrl_ff[`CTRL_DIR] &&
                        (bidir_mode_in || epp_mode_in);

  // Bus direction and control pins, idle follows control register
  always_comb begin
    if (in_cycle) begin
      parallel_data_oe_n_out = !(cyc_wr_ff || ctrl_ff[`CTRL_STROBE]);
      write_n_out = !(cyc_wr_ff || ctrl_ff[`CTRL_STROBE]);
      data_strobe_n_out = !(strobe_on && !cyc_addr_ff);
      address_strobe_n_out = !(strobe_on && cyc_addr_ff);
    end else begin
      parallel_data_oe_n_out = pins_in_mode;
      write_n_out = !ctrl_ff[`CTRL_STROBE];
      data_strobe_n_out = !ctrl_ff[`CTRL_AUTOFEED];
      address_strobe_n_out = !ctrl_ff[`CTRL_SELECT_IN];
    end
  end

  // Data and status outputs from flip-flops, except wait sync decoded from FIFO and state
  assign parallel_data_lines_out = out_ff;
  assign init_n_out = ctrl_ff[`CTRL_INIT];
  assign io_done_out = done_ff;
  assign io_rdata_out = rdata_ff;
  assign timeout_flag_out = tmo_ff;
  assign lpc_wait_sync_out = fifo_valid ||
                             (state_ff != epp_engine_pkg::ST_IDLE);

endmodule
`default_nettype wire

// ===== src/epp_engine_pkg.sv
// Types shared by the EPP cycle engine
package epp_engine_pkg;

  // ----------------------------------------------------------------------
  // Cycle engine states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WAIT_LOW,
    ST_SETUP,
    ST_STROBE,
    ST_FINISH
  } eng_state_e;

endpackage

// ===== src/epp_engine_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef EPP_ENGINE_REGS_SVH
`define EPP_ENGINE_REGS_SVH

// ----------------------------------------------------------------------
// Port offsets from the base
// ----------------------------------------------------------------------
`define OFF_DATA 3'h0
`define OFF_STATUS 3'h1
`define OFF_CONTROL 3'h2
`define OFF_EPP_ADDR 3'h3
`define OFF_EPP_DATA0 3'h4
`define OFF_EPP_DATA1 3'h5
`define OFF_EPP_DATA_TWO 3'h6
`define OFF_EPP_DATA_THREE 3'h7

// ----------------------------------------------------------------------
// Control and status fields
// ----------------------------------------------------------------------
`define CTRL_STROBE 0
`define CTRL_AUTOFEED 1
`define CTRL_INIT 2
`define CTRL_SELECT_IN 3
`define CTRL_DIR 5
`define CTRL_RESET 6'h00
`define STAT_TIMEOUT 0
`define DATA_RESET 8'h00
`define READ_IDLE 8'hFF

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_MHZ 40
`define TMO_US 10
`define TMO_CYC (`TMO_US * `CLK_MHZ)
`define TMO_CNT_W 9
`define FIFO_DEPTH 8
`define FIFO_WIDTH 12

`endif

// ===== src/pin_sync.sv
// Three-stage pin synchroniser, output moves when stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // Pin and filtered level
  input wire logic [WIDTH-1:0] pin_in,
  input wire logic [WIDTH-1:0] init_in,
  output logic [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;
  logic [WIDTH-1:0] q_ff;
  logic [WIDTH-1:0] nxt_q;
  logic init_done_ff;

  // Per bit: accept a change only once stages two and three match
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always_comb begin
        nxt_q[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : q_ff[i];
      end
    end
  endgenerate

  // Stage registers; the filtered level is preset once after release
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      q_ff <= '0;
      init_done_ff <= 1'b0;
    end else begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      init_done_ff <= 1'b1;
      q_ff <= init_done_ff ? nxt_q : init_in;
    end
  end

  assign level_out = q_ff;

endmodule
`default_nettype wire

// ===== src/req_fifo.sv
// Request FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none

module req_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // Fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ff;
  logic [AW:0] rd_ff;
  logic [AW:0] nxt_wr;
  logic [AW:0] nxt_rd;
  logic push;
  logic pop;

  // Full when pointers differ only in the wrap bit
  assign in_ready_out = (wr_ff != {~rd_ff[AW], rd_ff[AW-1:0]});
  assign out_valid_out = (wr_ff != rd_ff);
  assign out_data_out = mem[rd_ff[AW-1:0]];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  // Pointer advance
  always_comb begin
    nxt_wr = push ? wr_ff + 1'b1 : wr_ff;
    nxt_rd = pop ? rd_ff + 1'b1 : rd_ff;
  end

  // Pointer registers
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_ff <= '0;
      rd_ff <= '0;
    end else begin
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
    end
  end

  // Storage, no reset needed
  always_ff @(posedge sys_clk_in) begin
    if (push) begin
      mem[wr_ff[AW-1:0]] <= in_data_in;
    end
  end

endmodule
`default_nettype wire

// ===== test/epp_cycle_engine_sva.sv
// Port checker for the EPP cycle engine
`timescale 1ns/1ps
`default_nettype none

module epp_cycle_engine_sva (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // Watched ports
  input wire logic epp_v17_in,
  input wire logic periph_hold_n_in,
  input wire logic io_done_out,
  input wire logic lpc_wait_sync_out,
  input wire logic [7:0] parallel_data_lines_out,
  input wire logic parallel_data_oe_n_out,
  input wire logic write_n_out,
  input wire logic data_strobe_n_out,
  input wire logic timeout_flag_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);
  int low_cnt_ff;
  int nxt_low_cnt;

  // ----------------------------------------------------------------
  // Cycles spent with the data strobe low
  // ----------------------------------------------------------------
  always_comb begin
    nxt_low_cnt = data_strobe_n_out ? 0 : low_cnt_ff + 1;
  end
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      low_cnt_ff <= 0;
    end else begin
      low_cnt_ff <= nxt_low_cnt;
    end
  end

  // Strobe release followed by the ready pulse
  sequence s_strobe_end;
    data_strobe_n_out ##1 io_done_out;
  endsequence
  // Strobe held over two edges
  sequence s_strobe_on;
    !data_strobe_n_out ##1 !data_strobe_n_out;
  endsequence

  a_release_ends: assert property ($rose(periph_hold_n_in) &&
    !data_strobe_n_out |-> ##[2:8] s_strobe_end)
    else $error("strobe not ended after hold release");
  a_strobe_bound: assert property (low_cnt_ff < 404)
    else $error("strobe held past the watchdog");
  a_tmo_late: assert property ($rose(timeout_flag_out) &&
    !$past(data_strobe_n_out, 3) |-> $past(low_cnt_ff, 3) > 390)
    else $error("timeout flagged too early");
  a_tmo_done: assert property ($rose(timeout_flag_out)
    |-> ##[0:2] io_done_out)
    else $error("aborted cycle not closed");
  a_tmo_clear: assert property ($fell(timeout_flag_out)
    |-> ##[0:2] io_done_out)
    else $error("timeout flag cleared without a request");
  a_hold_first: assert property (!epp_v17_in &&
    $fell(data_strobe_n_out) |-> !$past(periph_hold_n_in, 3))
    else $error("strobe before hold went low");
  a_write_drives: assert property (!data_strobe_n_out &&
    !write_n_out && lpc_wait_sync_out |-> !parallel_data_oe_n_out)
    else $error("write strobe with bus floating");
  a_read_floats: assert property (!data_strobe_n_out &&
    write_n_out && lpc_wait_sync_out |-> parallel_data_oe_n_out)
    else $error("read strobe with bus driven");
  a_byte_holds: assert property (s_strobe_on
    |-> $stable(parallel_data_lines_out) &&
    parallel_data_lines_out == $past(parallel_data_lines_out, 2))
    else $error("bus byte moved under strobe");
endmodule

bind epp_cycle_engine epp_cycle_engine_sva u_sva (
  .sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
  .epp_v17_in(epp_v17_in), .periph_hold_n_in(periph_hold_n_in),
  .io_done_out(io_done_out), .lpc_wait_sync_out(lpc_wait_sync_out),
  .parallel_data_lines_out(parallel_data_lines_out),
  .parallel_data_oe_n_out(parallel_data_oe_n_out),
  .write_n_out(write_n_out), .data_strobe_n_out(data_strobe_n_out),
  .timeout_flag_out(timeout_flag_out)
);

`default_nettype wire

// ===== test/epp_periph_model.sv
// Behavioural EPP peripheral on the far side of the parallel bus
`timescale 1ns/1ps
`default_nettype none

module epp_periph_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Engine pins
  input wire logic data_strobe_n_in,
  input wire logic address_strobe_n_in,
  input wire logic write_n_in,
  input wire logic [7:0] lines_in,
  output logic [7:0] lines_out,
  output logic hold_n_out,
  // Scenario controls
  input wire logic [7:0] rd_byte_in,
  input wire logic stall_in,
  input wire logic idle_high_in,
  // What the peripheral received
  output logic [7:0] latched_out,
  output logic addr_seen_out,
  output logic [7:0] wr_count_out
);
  logic [3:0] dly_ff;

  // Answer a strobe with data, then release hold a few cycles later
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      dly_ff <= 4'h0;
      hold_n_out <= 1'b0;
      lines_out <= 8'h00;
      latched_out <= 8'h00;
      addr_seen_out <= 1'b0;
      wr_count_out <= 8'h00;
    end else if (!(data_strobe_n_in && address_strobe_n_in)) begin
      if (dly_ff != 4'hF) dly_ff <= dly_ff + 4'h1;
      if (write_n_in) lines_out <= rd_byte_in;
      if (dly_ff >= 4'h4 && !stall_in && !hold_n_out) begin
        hold_n_out <= 1'b1;
        addr_seen_out <= !address_strobe_n_in;
        if (!write_n_in) latched_out <= lines_in;
        if (!write_n_in) wr_count_out <= wr_count_out + 8'h01;
      end
    end else begin
      dly_ff <= 4'h0;
      hold_n_out <= idle_high_in;
      lines_out <= ~lines_out;
    end
  end
endmodule

`default_nettype wire

// ===== test/tb_epp_cycle_engine.sv
// Self-checking testbench for the EPP cycle engine
`timescale 1ns/1ps
`default_nettype none

module tb_epp_cycle_engine;
  logic clk, rstn, epp, v17, bidir, valid, wr, ready, done, lwait;
  logic oe_n, wrn, dsn, asn, initn, hold, tmo, stall, idle_hi, aseen;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, d_lines, m_lines, rd_byte, latched, wr_cnt;
  logic [7:0] bus, last_rd;
  int fail_count, num_checks, ndone, cyc;

  // Bus level from whichever side drives it
  assign bus = oe_n ? m_lines : d_lines;
  always #12.5 clk = ~clk;

  epp_cycle_engine uut (
    .sys_clk_in(clk), .resetn_in(rstn), .epp_mode_in(epp),
    .epp_v17_in(v17), .bidir_mode_in(bidir), .io_valid_in(valid),
    .io_ready_out(ready), .io_write_in(wr), .io_addr_in(addr),
    .io_wdata_in(wdata), .io_done_out(done), .io_rdata_out(rdata),
    .lpc_wait_sync_out(lwait), .parallel_data_lines_in(bus),
    .parallel_data_lines_out(d_lines), .parallel_data_oe_n_out(oe_n),
    .write_n_out(wrn), .data_strobe_n_out(dsn),
    .address_strobe_n_out(asn), .init_n_out(initn),
    .periph_hold_n_in(hold), .ack_n_in(1'b1), .paper_end_in(1'b0),
    .select_in(1'b1), .error_n_in(1'b1), .timeout_flag_out(tmo)
  );
  epp_periph_model u_periph (
    .clk_in(clk), .resetn_in(rstn), .data_strobe_n_in(dsn),
    .address_strobe_n_in(asn), .write_n_in(wrn), .lines_in(bus),
    .lines_out(m_lines), .hold_n_out(hold), .rd_byte_in(rd_byte),
    .stall_in(stall), .idle_high_in(idle_hi), .latched_out(latched),
    .addr_seen_out(aseen), .wr_count_out(wr_cnt)
  );

  // Count answers, keep their data and cut a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (done === 1'b1) begin
      ndone <= ndone + 1;
      last_rd <= rdata;
    end
    if (cyc == 20000) begin
      fail_count++;
      end_sim();
    end
  end

  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic io_start(logic w, logic [2:0] a, logic [7:0] d);
    @(negedge clk);
    valid = 1'b1;
    wr = w;
    addr = a;
    wdata = d;
    while (ready !== 1'b1) @(negedge clk);
    @(negedge clk);
    valid = 1'b0;
  endtask
  task automatic io_end(int n);
    int i;
    for (i = 0; i < 2000 && ndone <= n; i++) @(negedge clk);
    chk("answer", 8'h01, 8'(ndone > n));
  endtask
  task automatic io(logic w, logic [2:0] a, logic [7:0] d);
    int n;
    n = ndone;
    io_start(w, a, d);
    io_end(n);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_idle();
    io(1'b0, 3'h1, 8'h00);
    chk("status", 8'hD8, last_rd);
    io(1'b1, 3'h2, 8'h09);
    chk("pins", 8'h04, {4'h0, wrn, dsn, asn, initn});
    io(1'b1, 3'h0, 8'hC7);
    chk("bus", 8'hC7, d_lines);
    io(1'b0, 3'h0, 8'h00);
    chk("data", 8'hC7, last_rd);
    io(1'b0, 3'h2, 8'h00);
    chk("ctrl", 8'h09, last_rd);
    epp = 1'b0;
    io(1'b1, 3'h2, 8'h24);
    chk("oe", 8'h00, 8'(oe_n));
    io(1'b0, 3'h6, 8'h00);
    chk("rd", 8'hFF, last_rd);
    epp = 1'b1;
    io(1'b1, 3'h2, 8'h04);
  endtask
  task automatic t_write19();
    logic [2:0] a [4] = '{3'h3, 3'h4, 3'h6, 3'h7};
    foreach (a[i]) begin
      io(1'b1, a[i], 8'hA0 + 8'(i));
      chk("byte", 8'hA0 + 8'(i), latched);
      chk("astb", 8'(a[i] == 3'h3), 8'(aseen));
      chk("bus", 8'hA0 + 8'(i), d_lines);
    end
  endtask
  task automatic t_read19();
    rd_byte = 8'h3C;
    io(1'b0, 3'h5, 8'h00);
    chk("rd", 8'h3C, last_rd);
    rd_byte = 8'hC3;
    io(1'b0, 3'h3, 8'h00);
    chk("rd", 8'hC3, last_rd);
  endtask
  task automatic t_hold_high();
    int n;
    n = ndone;
    idle_hi = 1'b1;
    repeat (6) @(negedge clk);
    io_start(1'b1, 3'h4, 8'h96);
    repeat (30) @(negedge clk);
    chk("idle pins", 8'h07, {5'h0, lwait, dsn, wrn});
    idle_hi = 1'b0;
    io_end(n);
    chk("byte", 8'h96, latched);
  endtask
  task automatic t_fifo();
    int n, k;
    n = ndone;
    k = 0;
    stall = 1'b1;
    @(negedge clk);
    valid = 1'b1;
    wr = 1'b1;
    addr = 3'h4;
    while (ready === 1'b1 && k < 20) begin
      @(negedge clk);
      k++;
    end
    valid = 1'b0;
    stall = 1'b0;
    chk("queued", 8'h09, 8'(k));
    io_end(n + k - 1);
    chk("answers", 8'(k), 8'(ndone - n));
  endtask
  task automatic t_dir();
    logic [7:0] n;
    bidir = 1'b1;
    io(1'b1, 3'h2, 8'h24);
    chk("oe", 8'h01, 8'(oe_n));
    n = wr_cnt;
    io(1'b1, 3'h4, 8'h11);
    chk("writes", n, wr_cnt);
    chk("tmo", 8'h00, 8'(tmo));
    io(1'b1, 3'h2, 8'h05);
    io(1'b0, 3'h4, 8'h00);
    chk("writes", n + 8'h01, wr_cnt);
    bidir = 1'b0;
  endtask
  task automatic t_timeout();
    io(1'b1, 3'h2, 8'h04);
    stall = 1'b1;
    io(1'b0, 3'h4, 8'h00);
    chk("rd", 8'hFF, last_rd);
    chk("tmo", 8'h01, 8'(tmo));
    io(1'b1, 3'h1, 8'h00);
    chk("tmo", 8'h01, 8'(tmo));
    io(1'b1, 3'h1, 8'h01);
    chk("tmo", 8'h00, 8'(tmo));
    v17 = 1'b1;
    io(1'b1, 3'h2, 8'h00);
    io(1'b1, 3'h4, 8'h42);
    chk("tmo", 8'h01, 8'(tmo));
    io(1'b1, 3'h1, 8'h01);
    stall = 1'b0;
  endtask
  task automatic t_v17();
    io(1'b1, 3'h6, 8'h5A);
    chk("byte", 8'h5A, latched);
    chk("bus", 8'h5A, d_lines);
    rd_byte = 8'h69;
    io(1'b1, 3'h2, 8'h20);
    io(1'b0, 3'h4, 8'h00);
    chk("rd", 8'h69, last_rd);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Reset, then run every scenario in turn
  initial begin
    {clk, rstn, v17, bidir, valid, wr, stall, idle_hi} = '0;
    epp = 1'b1;
    addr = 3'h0;
    wdata = 8'h00;
    rd_byte = 8'h00;
    repeat (4) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    t_idle();
    t_write19();
    t_read19();
    t_hold_high();
    t_fifo();
    t_dir();
    t_timeout();
    t_v17();
    end_sim();
  end
endmodule

`default_nettype wire
